// *** mch_map.vh ***
// constants for the measurement-channel handshake block
`ifndef MCH_MAP_VH
`define MCH_MAP_VH
// ****************************************
// apb register offsets
// ****************************************
`define MCH_CTRL_OFS   12'h000
`define MCH_FDBK_OFS   12'h004
`define MCH_IRQ_ST_OFS 12'h008
`define MCH_IRQ_MK_OFS 12'h00C
`define MCH_CFG_OFS    12'h010
// ****************************************
// control fields
// ****************************************
`define MCH_C_DLOAD  0
`define MCH_C_PLOAD  1
`define MCH_C_OLOAD  2
`define MCH_C_ILOAD  3
`define MCH_C_ACK    4
`define MCH_C_RST    5
`define MCH_C_W      6
// ****************************************
// feedback fields
// ****************************************
`define MCH_F_CMP    0
`define MCH_F_HI     1
`define MCH_F_LO     2
`define MCH_F_RSTA   3
`define MCH_F_LERR   4
`define MCH_F_PERR   5
`define MCH_F_LRUN   6
`define MCH_F_ESUP   7
`define MCH_F_EOUT   8
`define MCH_F_EENC   9
`define MCH_F_W      10
// ****************************************
// config fields and misc
// ****************************************
`define MCH_G_ISO    0
`define MCH_G_GDIAG  1
`define MCH_G_W      2
`define MCH_ISO_CYC  3'h4
`define MCH_IRQ_W    4
`define MCH_ZERO32   32'h00000000
`endif

// *** mch_sync.v ***
// three-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module mch_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // data
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1[i]   <= 1'b0;
          s2[i]   <= 1'b0;
          s3[i]   <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          s1[i] <= din[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          // accept a change only once stages two and three agree
          if (s2[i] == s3[i]) begin
            dout[i] <= s3[i];
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** mch_diag.v ***
// latching diagnostic error flags with acknowledge
`timescale 1ns/1ps
`default_nettype none
`include "mch_map.vh"
module mch_diag #(
  parameter N = 3
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // control
  input  wire         ack,
  input  wire         stopped,
  input  wire         group_diag,
  // faults
  input  wire [N-1:0] fault,
  // outputs
  output reg  [N-1:0] err,
  output reg          diag_msg
);
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_err
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          err[i] <= 1'b0;
        end else if (ack || stopped) begin
          err[i] <= fault[i];
        end else if (fault[i]) begin
          err[i] <= 1'b1;
        end
      end
    end
  endgenerate
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_msg <= 1'b0;
    end else begin
      diag_msg <= group_diag && (|err);
    end
  end
endmodule
`default_nettype wire

// *** mch_top.v ***
// measurement channel control and feedback handshake with apb registers
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mch_map.vh"
module mch_top (
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // bus cycle and controller state
  input  wire        bus_tick,
  input  wire        ctrl_stop,
  // measurement events from the datapath
  input  wire        meas_done,
  input  wire        meas_estimated,
  input  wire        meas_continuous,
  input  wire        high_limit_evt,
  input  wire        low_limit_evt,
  input  wire        load_value_ok,
  input  wire        load_done,
  // parameter assignment
  input  wire        param_assign,
  input  wire        param_valid,
  // fault pins
  input  wire        supply_fault_pin,
  input  wire        output_fault_pin,
  input  wire        encoder_fault_pin,
  // outputs
  output wire        diag_msg,
  output wire        irq
);
  // ****************************************
  // registers
  // ****************************************
  reg  [`MCH_C_W-1:0]   ctrl;
  reg  [`MCH_G_W-1:0]   cfg;
  reg  [`MCH_IRQ_W-1:0] irq_st;
  reg  [`MCH_IRQ_W-1:0] irq_mk;
  reg                   meas_complete_flag;
  reg                   high_limit_flag;
  reg                   low_limit_flag;
  reg                   reset_active_flag;
  reg                   load_error_flag;
  reg                   param_error_flag;
  reg                   load_running_flag;
  reg  [2:0]            rst_cnt;
  reg  [2:0]            load_cnt;
  wire [2:0]            fault_sync;
  wire [2:0]            diag_err;
  wire                  wr = psel && penable && pwrite;
  wire direct_load_req       = ctrl[`MCH_C_DLOAD];
  wire prepared_load_req     = ctrl[`MCH_C_PLOAD];
  wire output_param_load_req = ctrl[`MCH_C_OLOAD];
  wire integ_time_load_req   = ctrl[`MCH_C_ILOAD];
  wire error_ack_bit         = ctrl[`MCH_C_ACK];
  wire status_reset_req      = ctrl[`MCH_C_RST];
  wire [3:0] load_reqs = {integ_time_load_req, output_param_load_req, prepared_load_req, direct_load_req};
  wire any_load  = |load_reqs;
  // more than one request bit set
  wire conflict  = any_load && ((load_reqs & (load_reqs - 4'h1)) != 4'h0);
  wire iso       = cfg[`MCH_G_ISO];
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  // ****************************************
  // fault inputs and diagnostics
  // ****************************************
  mch_sync #(.W(3)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({encoder_fault_pin, output_fault_pin, supply_fault_pin}),
    .dout    (fault_sync)
  );
  mch_diag #(.N(3)) u_diag (
    .pclk       (pclk),
    .presetn    (presetn),
    .ack        (error_ack_bit),
    .stopped    (ctrl_stop),
    .group_diag (cfg[`MCH_G_GDIAG]),
    .fault      (fault_sync),
    .err        (diag_err),
    .diag_msg   (diag_msg)
  );
  // ****************************************
  // apb write side
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= {`MCH_C_W{1'b0}};
      cfg    <= {`MCH_G_W{1'b0}};
      irq_mk <= {`MCH_IRQ_W{1'b0}};
    end else if (wr) begin
      if (paddr == `MCH_CTRL_OFS) begin
        ctrl <= pwdata[`MCH_C_W-1:0];
      end else if (paddr == `MCH_IRQ_MK_OFS) begin
        irq_mk <= pwdata[`MCH_IRQ_W-1:0];
      end else if (paddr == `MCH_CFG_OFS) begin
        cfg <= pwdata[`MCH_G_W-1:0];
      end
    end
  end
  // ****************************************
  // status reset handshake
  // ****************************************
  // in isochrone mode the active phase is paced by bus ticks so the
  // controller sees a fixed four-cycle exchange
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_active_flag <= 1'b0;
      rst_cnt           <= 3'h0;
    end else if (status_reset_req && !reset_active_flag) begin
      reset_active_flag <= 1'b1;
      rst_cnt           <= 3'h1;
    end else if (reset_active_flag) begin
      if (iso) begin
        if (bus_tick && rst_cnt != `MCH_ISO_CYC) begin
          rst_cnt <= rst_cnt + 3'h1;
        end
        if (rst_cnt == `MCH_ISO_CYC && !status_reset_req) begin
          reset_active_flag <= 1'b0;
          rst_cnt           <= 3'h0;
        end
      end else if (!status_reset_req) begin
        reset_active_flag <= 1'b0;
        rst_cnt           <= 3'h0;
      end
    end
  end
  // ****************************************
  // status flags
  // ****************************************
  wire real_value = meas_done && !(meas_continuous && meas_estimated);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_complete_flag <= 1'b0;
      high_limit_flag    <= 1'b0;
      low_limit_flag     <= 1'b0;
    end else begin
      // a fresh event wins over a pending reset
      if (real_value) begin
        meas_complete_flag <= 1'b1;
      end else if (status_reset_req) begin
        meas_complete_flag <= 1'b0;
      end
      if (high_limit_evt) begin
        high_limit_flag <= 1'b1;
      end else if (status_reset_req) begin
        high_limit_flag <= 1'b0;
      end
      if (low_limit_evt) begin
        low_limit_flag <= 1'b1;
      end else if (status_reset_req) begin
        low_limit_flag <= 1'b0;
      end
    end
  end
  // ****************************************
  // load function
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_error_flag   <= 1'b0;
      load_running_flag <= 1'b0;
      load_cnt          <= 3'h0;
    end else begin
      if (conflict) begin
        load_error_flag <= 1'b1;
      end else if (any_load && load_done && !load_value_ok) begin
        load_error_flag <= 1'b1;
      end else if (any_load && load_done && load_value_ok) begin
        load_error_flag <= 1'b0;
      end
      if (any_load && !conflict && !load_running_flag) begin
        load_running_flag <= 1'b1;
        load_cnt          <= 3'h1;
      end else if (load_running_flag) begin
        if (iso) begin
          if (bus_tick && load_cnt != `MCH_ISO_CYC) begin
            load_cnt <= load_cnt + 3'h1;
          end
          if (load_cnt == `MCH_ISO_CYC && !any_load) begin
            load_running_flag <= 1'b0;
            load_cnt          <= 3'h0;
          end
        end else if (!any_load) begin
          load_running_flag <= 1'b0;
          load_cnt          <= 3'h0;
        end
      end
    end
  end
  // ****************************************
  // parameter error
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      param_error_flag <= 1'b0;
    end else if (param_assign) begin
      param_error_flag <= !param_valid;
    end
  end
  // ****************************************
  // interrupts: cmp, load err, param err, diag
  // ****************************************
  wire [`MCH_IRQ_W-1:0] irq_evt = {|diag_err, param_error_flag, load_error_flag, real_value};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st <= {`MCH_IRQ_W{1'b0}};
    end else begin
      // set wins over write-one-to-clear
      irq_st <= irq_evt | (irq_st & ~((wr && paddr == `MCH_IRQ_ST_OFS) ? pwdata[`MCH_IRQ_W-1:0] :
                                      {`MCH_IRQ_W{1'b0}}));
    end
  end
  assign irq = |(irq_st & irq_mk);
  // ****************************************
  // apb read side
  // ****************************************
  wire [`MCH_F_W-1:0] fdbk = {diag_err, load_running_flag, param_error_flag, load_error_flag,
                              reset_active_flag, low_limit_flag, high_limit_flag, meas_complete_flag};
  always @* begin
    prdata = `MCH_ZERO32;
    if (paddr == `MCH_CTRL_OFS) begin
      prdata[`MCH_C_W-1:0] = ctrl;
    end else if (paddr == `MCH_FDBK_OFS) begin
      prdata[`MCH_F_W-1:0] = fdbk;
    end else if (paddr == `MCH_IRQ_ST_OFS) begin
      prdata[`MCH_IRQ_W-1:0] = irq_st;
    end else if (paddr == `MCH_IRQ_MK_OFS) begin
      prdata[`MCH_IRQ_W-1:0] = irq_mk;
    end else if (paddr == `MCH_CFG_OFS) begin
      prdata[`MCH_G_W-1:0] = cfg;
    end
  end
endmodule
`default_nettype wire

// *** mch_fbm.sv ***
// bus cycle source standing in for the fieldbus master
`timescale 1ns/1ps
`default_nettype none
module mch_fbm #(
  parameter int PERIOD = 10
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // bus cycle
  output var  logic bus_tick
);
  int cnt;
  // one tick per bus cycle paces the handshake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      bus_tick <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      bus_tick <= (cnt == PERIOD - 1);
    end
  end
endmodule
`default_nettype wire

// *** mch_chk_assertions.sv ***
// port checker for the measurement channel handshake
`timescale 1ns/1ps
`default_nettype none
module mch_chk (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // events and outputs
  input wire logic        load_done,
  input wire logic        param_assign,
  input wire logic        diag_msg,
  input wire logic        irq
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr_ct = psel && penable && pwrite && paddr == 12'h000;
  wire rd_fb = psel && paddr == 12'h004;
  a_ready_okay: assert property (pready && !pslverr)
    else $error("apb answer not zero-wait okay");
  a_unmapped_zero: assert property (psel && paddr == 12'h014 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_conflict_err: assert property (wr_ct && $countones(pwdata[3:0]) > 1 ##2 rd_fb |-> prdata[4])
    else $error("load conflict not flagged");
  a_lerr_hold: assert property (rd_fb && prdata[4] && !load_done ##1 rd_fb |-> prdata[4])
    else $error("load error dropped without load");
  a_perr_hold: assert property (rd_fb && prdata[5] && !param_assign ##1 rd_fb |-> prdata[5])
    else $error("param error dropped without assignment");
  a_reset_active: assert property (wr_ct && pwdata[5] ##2 rd_fb |-> prdata[3] && !prdata[0])
    else $error("status reset not active");
  a_mask_quiet: assert property (psel && penable && pwrite && paddr == 12'h00C && pwdata[3:0] == 4'h0 |=> !irq)
    else $error("irq high with all masked");
  a_group_off: assert property (psel && paddr == 12'h010 && !prdata[1] |=> !diag_msg)
    else $error("diag message with group off");
endmodule
bind mch_top mch_chk mch_chk_i (.*);
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the measurement channel handshake
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, bus_tick, diag_msg, irq, mcont = 1'b0, mest = 1'b0, lok = 1'b0, pval = 1'b0;
  logic        stp = 1'b0;
  logic [4:0]  evt = 5'h0;
  logic [2:0]  fpin = 3'h0;
  int          n_fail = 0, checks_done = 0;
  localparam logic [11:0] CT = 12'h000, FB = 12'h004, IS = 12'h008, IM = 12'h00C, CF = 12'h010;
  always #12.5 pclk = ~pclk;
  mch_fbm #(.PERIOD(10)) mch_fbm_i (.pclk(pclk), .presetn(presetn), .bus_tick(bus_tick));
  mch_top mch_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_tick(bus_tick), .ctrl_stop(stp), .meas_done(evt[4]), .meas_estimated(mest),
    .meas_continuous(mcont), .high_limit_evt(evt[3]), .low_limit_evt(evt[2]), .load_value_ok(lok),
    .load_done(evt[1]), .param_assign(evt[0]), .param_valid(pval), .supply_fault_pin(fpin[0]),
    .output_fault_pin(fpin[1]), .encoder_fault_pin(fpin[2]), .diag_msg(diag_msg), .irq(irq));
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // holds the request until pready is seen at an edge
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // a slave that never answers counts as a mismatch
    if (n >= 20) begin
      n_fail++;
      $display("unexpected at %0t: no pready", $time);
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(q & m, e);
  endtask
  task automatic ev(input logic [4:0] v);
    @(posedge pclk);
    evt <= v;
    @(posedge pclk);
    evt <= 5'h0;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(CT, 32'hFFFFFFFF, 32'h0);
    rd(FB, 32'hFFFFFFFF, 32'h0);
    rd(CF, 32'hFFFFFFFF, 32'h0);
    xfer(12'h014, 1'b1, 32'hFFFFFFFF);
    rd(12'h014, 32'hFFFFFFFF, 32'h0);
    ev(5'h1C);
    rd(FB, 32'h7, 32'h7);
    xfer(CT, 1'b1, 32'h20);
    rd(FB, 32'hF, 32'h8);
    xfer(CT, 1'b1, 32'h0);
    rd(FB, 32'h8, 32'h0);
    mcont <= 1'b1;
    mest <= 1'b1;
    ev(5'h10);
    rd(FB, 32'h1, 32'h0);
    mest <= 1'b0;
    ev(5'h10);
    rd(FB, 32'h1, 32'h1);
    for (int i = 0; i < 4; i++) begin
      xfer(CT, 1'b1, 32'h1 << i);
      rd(FB, 32'h50, 32'h40);
      xfer(CT, 1'b1, 32'h0);
    end
    xfer(CT, 1'b1, 32'hC);
    rd(FB, 32'h10, 32'h10);
    xfer(CT, 1'b1, 32'h0);
    rd(FB, 32'h10, 32'h10);
    xfer(CT, 1'b1, 32'h1);
    lok <= 1'b1;
    ev(5'h02);
    rd(FB, 32'h10, 32'h0);
    xfer(CT, 1'b1, 32'h0);
    ev(5'h01);
    xfer(CT, 1'b1, 32'h30);
    rd(FB, 32'h20, 32'h20);
    xfer(CT, 1'b1, 32'h0);
    pval <= 1'b1;
    ev(5'h01);
    rd(FB, 32'h20, 32'h0);
    xfer(CF, 1'b1, 32'h1);
    xfer(CT, 1'b1, 32'h20);
    xfer(CT, 1'b1, 32'h0);
    rd(FB, 32'h8, 32'h8);
    repeat (60) @(posedge pclk);
    rd(FB, 32'h8, 32'h0);
    xfer(CF, 1'b1, 32'h0);
    fpin <= 3'h1;
    repeat (10) @(posedge pclk);
    fpin <= 3'h0;
    repeat (10) @(posedge pclk);
    rd(FB, 32'h380, 32'h80);
    chk(32'(diag_msg), 32'h0);
    xfer(CF, 1'b1, 32'h2);
    repeat (2) @(posedge pclk);
    chk(32'(diag_msg), 32'h1);
    xfer(CT, 1'b1, 32'h10);
    repeat (10) @(posedge pclk);
    rd(FB, 32'h380, 32'h0);
    fpin <= 3'h6;
    repeat (10) @(posedge pclk);
    rd(FB, 32'h380, 32'h300);
    fpin <= 3'h0;
    repeat (10) @(posedge pclk);
    rd(FB, 32'h380, 32'h0);
    // stopped controller without acknowledge: flags follow faults too
    xfer(CT, 1'b1, 32'h0);
    stp <= 1'b1;
    fpin <= 3'h1;
    repeat (10) @(posedge pclk);
    rd(FB, 32'h380, 32'h80);
    fpin <= 3'h0;
    repeat (10) @(posedge pclk);
    rd(FB, 32'h380, 32'h0);
    stp <= 1'b0;
    xfer(IM, 1'b1, 32'hF);
    @(posedge pclk);
    chk(32'(irq), 32'h1);
    xfer(IM, 1'b1, 32'h0);
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    xfer(IS, 1'b1, 32'hF);
    rd(IS, 32'hF, 32'h0);
    end_sim;
  end
  // hang guard: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    end_sim;
  end
endmodule
`default_nettype wire
